// ### common/spfc_pkg.sv
// Shared constants and types for the serial port with flow control
package spfc_pkg;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned CLK_HZ        = 1000000000 / CLK_PERIOD_NS;
   localparam int unsigned WAIT_UNIT_NS  = 1000000;
   localparam int unsigned CYC_PER_MS    = WAIT_UNIT_NS / CLK_PERIOD_NS;

   // Bit period in clocks for each selectable rate, index 0 to 10
   localparam int unsigned BAUD_NUM = 11;
   localparam logic [19:0] BIT_DIV [0:BAUD_NUM-1] = '{
      20'(CLK_HZ / 300),   20'(CLK_HZ / 600),   20'(CLK_HZ / 1200),  20'(CLK_HZ / 2400),
      20'(CLK_HZ / 4800),  20'(CLK_HZ / 9600),  20'(CLK_HZ / 19200), 20'(CLK_HZ / 38400),
      20'(CLK_HZ / 57600), 20'(CLK_HZ / 76800), 20'(CLK_HZ / 115200)};
   localparam logic [3:0]  BAUD_DEF = 4'h5;
   localparam logic [3:0]  BAUD_MAX = 4'ha;

   // ****************************************************************
   // Register map (byte addresses)
   // ****************************************************************
   localparam logic [4:0] ADDR_CTRL    = 5'h00;
   localparam logic [4:0] ADDR_STORED  = 5'h04;
   localparam logic [4:0] ADDR_RUNCFG  = 5'h08;
   localparam logic [4:0] ADDR_XCHAR   = 5'h0c;
   localparam logic [4:0] ADDR_TXDATA  = 5'h10;
   localparam logic [4:0] ADDR_RXDATA  = 5'h14;
   localparam logic [4:0] ADDR_STATUS  = 5'h18;

   localparam int unsigned CTRL_RUN     = 0;
   localparam int unsigned RX_VALID_BIT = 8;
   localparam int unsigned ST_BUSY      = 0;
   localparam int unsigned ST_HALT      = 1;
   localparam int unsigned ST_ABORT     = 2;
   localparam int unsigned ST_CFGERR    = 3;
   localparam int unsigned ST_CTS       = 4;
   localparam int unsigned ST_DSR       = 5;
   localparam int unsigned ST_XOFF      = 6;
   localparam int unsigned ST_RUNCFG    = 7;
   localparam int unsigned ST_RS485     = 8;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [2:0] {PAR_NONE, PAR_EVEN, PAR_ODD, PAR_MARK, PAR_SPACE} spfc_par_t;
   typedef enum logic [1:0] {FLOW_NONE, FLOW_HW, FLOW_SW} spfc_flow_t;
   typedef enum logic [1:0] {TX_IDLE, TX_HOLD, TX_SHIFT} spfc_tx_st_t;

   typedef struct packed {
      logic [15:0] wait_ms;
      logic [4:0]  rsvd;
      logic        rts_always;
      spfc_flow_t  flow;
      logic        stop2;
      spfc_par_t   parity;
      logic [3:0]  baud;
   } spfc_cfg_t;

   typedef struct packed {
      logic        read;
      logic        write;
      logic [4:0]  address;
      logic [31:0] writedata;
      logic [3:0]  byteenable;
   } spfc_avs_req_t;

   localparam spfc_cfg_t CFG_RST = '{wait_ms: 16'h03e8, rsvd: 5'h00, rts_always: 1'b0,
                                     flow: FLOW_NONE, stop2: 1'b0, parity: PAR_NONE, baud: BAUD_DEF};
   localparam logic [7:0] XON_RST  = 8'h11;
   localparam logic [7:0] XOFF_RST = 8'h13;

endpackage : spfc_pkg

// ### hw/spfc_top.sv
// Serial port with configuration registers and transmit flow control
`timescale 1ns/10ps
`default_nettype none
// How it works
// [R1] Eleven bit rates, 9600 after reset
// [R2] Parity none, even, odd, mark, space
// [R3] One or two stop bits, one default
// [R4] Wait time in milliseconds, 16 bits
// [R5] Missed CTS or XON aborts, flags error
// [R6] RS-485 variant runs without flow control
// [R7] Drives RTS, watches CTS as DTE
// [R8] RTS always or switched; XON/XOFF codes programmable
// [R9] Switched: RTS on data, send while CTS
// [R10] CTS low halts, CTS high resumes; in always mode the code ignores CTS and does not halt
// [R11] CTS low past wait time aborts; the code aborts on CTS in switched mode only
// [R12] Always mode keeps RTS asserted
// [R13] Far sender must not overrun receiver
// [R14] DTR asserted under hardware flow control
// [R15] DSR checked only at send start
// [R16] XOFF stops sending, XON resumes
// [R17] No XON within wait time aborts
// [R18] XON and XOFF codes must differ
// [R19] Software flow only for ASCII traffic
// [R20] Runtime settings override stored, lost on reset
// [R21] Leaving run reloads stored settings
// [R22] Halt between whole characters, line idle
module spfc_top
   import spfc_pkg::*;
#(
   parameter int unsigned MS_CYCLES = CYC_PER_MS
)(
   // Clock and reset
   input  wire logic          clk_i,
   input  wire logic          sys_rst_i,
   // Avalon-MM slave
   input  wire spfc_avs_req_t avs_req_i,
   output var  logic [31:0]   avs_readdata_o,
   output var  logic          avs_waitrequest_o,
   // Serial pins
   input  wire logic          rxd_i,
   input  wire logic          cts_i,
   input  wire logic          dsr_i,
   input  wire logic          rs485_variant_i,
   output var  logic          txd_o,
   output var  logic          rts_o,
   output var  logic          dtr_o
);

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   logic [3:0] pin_meta_r;
   logic [3:0] pin_sync_r;
   logic       rxd_s;
   logic       cts_s;
   logic       dsr_s;
   logic       rs485_s;

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pin_meta_r <= 4'h7;
         pin_sync_r <= 4'h7;
      end else begin
         pin_meta_r <= {rs485_variant_i, dsr_i, cts_i, rxd_i};
         pin_sync_r <= pin_meta_r;
      end
   end

   assign rxd_s   = pin_sync_r[0];
   assign cts_s   = pin_sync_r[1];
   assign dsr_s   = pin_sync_r[2];
   assign rs485_s = pin_sync_r[3];

   // ****************************************************************
   // Bus handshake
   // ****************************************************************
   function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
      logic [31:0] m;
      m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      return (old & ~m) | (wd & m);
   endfunction : be_merge

   function automatic logic cfg_ok(input spfc_cfg_t c);
      return (c.baud <= BAUD_MAX) && (c.parity <= PAR_SPACE) && (2'(c.flow) != 2'h3);
   endfunction : cfg_ok

   spfc_cfg_t   stored_cfg_r;
   spfc_cfg_t   run_cfg_r;
   spfc_cfg_t   eff_cfg;
   spfc_cfg_t   cand_cfg;
   spfc_flow_t  flow_eff;
   spfc_tx_st_t tx_state_r;
   logic        run_r;
   logic        run_valid_r;
   logic [7:0]  xon_r;
   logic [7:0]  xoff_r;
   logic [7:0]  hold_r;
   logic        hold_valid_r;
   logic [7:0]  rx_data_r;
   logic        rx_valid_r;
   logic        rx_done_r;
   logic [7:0]  rx_sh_r;
   logic        xoff_held_r;
   logic        abort_err_r;
   logic        cfg_err_r;
   logic        acc;
   logic        wr;
   logic        tx_take;
   logic        tx_abort;
   logic        go;
   logic        timeout;
   logic [31:0] rd_nxt;
   logic [31:0] xch_cand;

   assign acc = ~avs_waitrequest_o & (avs_req_i.read | avs_req_i.write);
   assign wr  = acc & avs_req_i.write;

   // A full holding byte stalls a transmit-data write until the shifter takes it or an abort drops it
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         avs_waitrequest_o <= 1'b1;
      end else if (!avs_waitrequest_o) begin
         avs_waitrequest_o <= 1'b1;
      end else if ((avs_req_i.read | avs_req_i.write)
                   && !(avs_req_i.write && avs_req_i.address == ADDR_TXDATA && hold_valid_r)) begin
         avs_waitrequest_o <= 1'b0;
      end
   end

   always_comb begin
      rd_nxt = 32'h0000_0000;
      case (avs_req_i.address)
         ADDR_CTRL:   rd_nxt[CTRL_RUN] = run_r;
         ADDR_STORED: rd_nxt = stored_cfg_r;
         ADDR_RUNCFG: rd_nxt = run_cfg_r;
         ADDR_XCHAR:  rd_nxt = {16'h0000, xoff_r, xon_r};
         ADDR_RXDATA: rd_nxt = {23'h000000, rx_valid_r, rx_data_r};
         ADDR_STATUS: begin
            rd_nxt[ST_BUSY]   = tx_state_r != TX_IDLE;
            rd_nxt[ST_HALT]   = tx_state_r == TX_HOLD;
            rd_nxt[ST_ABORT]  = abort_err_r;
            rd_nxt[ST_CFGERR] = cfg_err_r;
            rd_nxt[ST_CTS]    = cts_s;
            rd_nxt[ST_DSR]    = dsr_s;
            rd_nxt[ST_XOFF]   = xoff_held_r;
            rd_nxt[ST_RUNCFG] = run_valid_r;
            rd_nxt[ST_RS485]  = rs485_s;
         end
         default:     rd_nxt = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         avs_readdata_o <= 32'h0000_0000;
      end else if (avs_waitrequest_o) begin
         avs_readdata_o <= avs_req_i.read ? rd_nxt : 32'h0000_0000;
      end
   end

   // ****************************************************************
   // Configuration
   // ****************************************************************
   assign cand_cfg = spfc_cfg_t'(be_merge(32'(avs_req_i.address == ADDR_RUNCFG ? run_cfg_r : stored_cfg_r),
                                          avs_req_i.writedata, avs_req_i.byteenable) & 32'hffff_07ff);
   assign xch_cand = be_merge({16'h0000, xoff_r, xon_r}, avs_req_i.writedata, avs_req_i.byteenable);
   assign eff_cfg  = run_valid_r ? run_cfg_r : stored_cfg_r; // R20
   assign flow_eff = rs485_s ? FLOW_NONE : eff_cfg.flow; // R6

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         run_r        <= 1'b0;
         stored_cfg_r <= CFG_RST; // R1 R2 R3
         run_cfg_r    <= CFG_RST;
         run_valid_r  <= 1'b0; // R20
      end else begin
         if (wr && avs_req_i.address == ADDR_CTRL && avs_req_i.byteenable[0]) begin
            run_r <= avs_req_i.writedata[CTRL_RUN];
         end
         if (wr && avs_req_i.address == ADDR_STORED && cfg_ok(cand_cfg)) begin
            stored_cfg_r <= cand_cfg;
         end
         if (run_r && wr && avs_req_i.address == ADDR_RUNCFG && cfg_ok(cand_cfg)) begin
            run_cfg_r   <= cand_cfg;
            run_valid_r <= 1'b1; // R20
         end else if (!run_r) begin
            run_valid_r <= 1'b0; // R21
         end
      end
   end

   // Equal codes are refused so the pair stays unambiguous
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         xon_r  <= XON_RST;
         xoff_r <= XOFF_RST;
      end else if (wr && avs_req_i.address == ADDR_XCHAR && xch_cand[7:0] != xch_cand[15:8]) begin
         xon_r  <= xch_cand[7:0]; // R8 R18
         xoff_r <= xch_cand[15:8];
      end
   end

   // ****************************************************************
   // Holding byte and sticky flags
   // ****************************************************************
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         hold_r       <= 8'h00;
         hold_valid_r <= 1'b0;
      end else if (wr && avs_req_i.address == ADDR_TXDATA
                   && !(flow_eff == FLOW_SW && avs_req_i.writedata[7])) begin
         hold_r       <= avs_req_i.writedata[7:0]; // R19
         hold_valid_r <= 1'b1;
      end else if (tx_take || tx_abort) begin
         hold_valid_r <= 1'b0; // R5
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         abort_err_r <= 1'b0;
         cfg_err_r   <= 1'b0;
      end else begin
         if (tx_abort) begin
            abort_err_r <= 1'b1; // R5 R11 R17
         end else if (wr && avs_req_i.address == ADDR_STATUS && avs_req_i.byteenable[0]
                      && avs_req_i.writedata[ST_ABORT]) begin
            abort_err_r <= 1'b0;
         end
         if (wr && ((avs_req_i.address == ADDR_XCHAR && xch_cand[7:0] == xch_cand[15:8])
                    || (avs_req_i.address == ADDR_TXDATA && flow_eff == FLOW_SW && avs_req_i.writedata[7])
                    || ((avs_req_i.address == ADDR_STORED || avs_req_i.address == ADDR_RUNCFG)
                        && !cfg_ok(cand_cfg)))) begin
            cfg_err_r <= 1'b1; // R18 R19
         end else if (wr && avs_req_i.address == ADDR_STATUS && avs_req_i.byteenable[0]
                      && avs_req_i.writedata[ST_CFGERR]) begin
            cfg_err_r <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // Flow permission and wait timer
   // ****************************************************************
   logic        first_r;
   logic [16:0] ms_pre_r;
   logic [15:0] ms_cnt_r;

   always_comb begin
      case (flow_eff)
         FLOW_HW: go = (!first_r || dsr_s) && (eff_cfg.rts_always || cts_s); // R9 R10 R15
         FLOW_SW: go = !xoff_held_r; // R16
         default: go = 1'b1;
      endcase
   end

   assign timeout  = ms_cnt_r >= eff_cfg.wait_ms; // R4
   assign tx_take  = tx_state_r == TX_HOLD && go;
   assign tx_abort = tx_state_r == TX_HOLD && !go && timeout; // R5 R11 R17

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ms_pre_r <= 17'h00000;
         ms_cnt_r <= 16'h0000;
      end else if (tx_state_r != TX_HOLD || go) begin
         ms_pre_r <= 17'h00000;
         ms_cnt_r <= 16'h0000;
      end else if (ms_pre_r == 17'(MS_CYCLES - 1)) begin
         ms_pre_r <= 17'h00000;
         ms_cnt_r <= ms_cnt_r + 16'h0001; // R4
      end else begin
         ms_pre_r <= ms_pre_r + 17'h00001;
      end
   end

   // ****************************************************************
   // Transmitter
   // ****************************************************************
   logic [19:0] tx_div_r;
   logic [19:0] tx_tmr_r;
   logic [10:0] tx_sh_r;
   logic [3:0]  tx_left_r;
   logic        has_par;
   logic        par_bit;

   assign has_par = eff_cfg.parity != PAR_NONE;

   always_comb begin
      case (eff_cfg.parity)
         PAR_EVEN:  par_bit = ^hold_r; // R2
         PAR_ODD:   par_bit = ~^hold_r;
         PAR_MARK:  par_bit = 1'b1;
         default:   par_bit = 1'b0;
      endcase
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         tx_state_r <= TX_IDLE;
         first_r    <= 1'b0;
         txd_o      <= 1'b1;
         tx_div_r   <= 20'h00000;
         tx_tmr_r   <= 20'h00000;
         tx_sh_r    <= 11'h7ff;
         tx_left_r  <= 4'h0;
      end else begin
         case (tx_state_r)
            TX_IDLE: begin
               if (hold_valid_r) begin
                  tx_state_r <= TX_HOLD;
                  first_r    <= 1'b1; // R15
               end
            end
            TX_HOLD: begin
               if (tx_take) begin
                  tx_state_r <= TX_SHIFT;
                  txd_o      <= 1'b0;
                  tx_div_r   <= BIT_DIV[eff_cfg.baud]; // R1
                  tx_tmr_r   <= BIT_DIV[eff_cfg.baud] - 20'h00001;
                  tx_sh_r    <= has_par ? {2'b11, par_bit, hold_r} : {3'b111, hold_r};
                  tx_left_r  <= 4'(9 + 32'(has_par) + 32'(eff_cfg.stop2)); // R3
               end else if (tx_abort) begin
                  tx_state_r <= TX_IDLE;
                  first_r    <= 1'b0;
               end
            end
            TX_SHIFT: begin
               if (tx_tmr_r != 20'h00000) begin
                  tx_tmr_r <= tx_tmr_r - 20'h00001;
               end else if (tx_left_r == 4'h0) begin
                  // Whole character out before flow control is looked at again
                  tx_state_r <= hold_valid_r ? TX_HOLD : TX_IDLE; // R22
                  first_r    <= 1'b0;
               end else begin
                  txd_o     <= tx_sh_r[0];
                  tx_sh_r   <= {1'b1, tx_sh_r[10:1]};
                  tx_left_r <= tx_left_r - 4'h1;
                  tx_tmr_r  <= tx_div_r - 20'h00001;
               end
            end
            default: tx_state_r <= TX_IDLE;
         endcase
      end
   end

   // Handshake outputs follow the effective mode; RS-485 forces both off
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rts_o <= 1'b0;
         dtr_o <= 1'b0;
      end else begin
         rts_o <= flow_eff == FLOW_HW && (eff_cfg.rts_always || tx_state_r != TX_IDLE); // R7 R9 R12
         dtr_o <= flow_eff == FLOW_HW; // R14
      end
   end

   // ****************************************************************
   // Receiver
   // ****************************************************************
   logic        rx_busy_r;
   logic        rx_prev_r;
   logic [19:0] rx_tmr_r;
   logic [3:0]  rx_idx_r;
   logic [19:0] rx_div;

   assign rx_div = BIT_DIV[eff_cfg.baud];

   // Parity is not checked; the slot is simply skipped
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rx_busy_r <= 1'b0;
         rx_prev_r <= 1'b1;
         rx_tmr_r  <= 20'h00000;
         rx_idx_r  <= 4'h0;
         rx_sh_r   <= 8'h00;
         rx_done_r <= 1'b0;
      end else begin
         rx_prev_r <= rxd_s;
         rx_done_r <= 1'b0;
         if (!rx_busy_r) begin
            if (rx_prev_r && !rxd_s) begin
               rx_busy_r <= 1'b1;
               rx_tmr_r  <= {1'b0, rx_div[19:1]};
               rx_idx_r  <= 4'h0;
            end
         end else if (rx_tmr_r != 20'h00000) begin
            rx_tmr_r <= rx_tmr_r - 20'h00001;
         end else begin
            rx_tmr_r <= rx_div - 20'h00001;
            rx_idx_r <= rx_idx_r + 4'h1;
            if (rx_idx_r == 4'h0 && rxd_s) begin
               rx_busy_r <= 1'b0;
            end else if (rx_idx_r >= 4'h1 && rx_idx_r <= 4'h8) begin
               rx_sh_r <= {rxd_s, rx_sh_r[7:1]};
            end else if (rx_idx_r == (has_par ? 4'ha : 4'h9)) begin
               rx_busy_r <= 1'b0;
               rx_done_r <= rxd_s;
            end
         end
      end
   end

   // Flow characters are consumed, not handed to software
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rx_data_r   <= 8'h00;
         rx_valid_r  <= 1'b0;
         xoff_held_r <= 1'b0;
      end else begin
         if (flow_eff != FLOW_SW) begin
            xoff_held_r <= 1'b0;
         end else if (rx_done_r && rx_sh_r == xoff_r) begin
            xoff_held_r <= 1'b1; // R16
         end else if (rx_done_r && rx_sh_r == xon_r) begin
            xoff_held_r <= 1'b0; // R16
         end
         if (rx_done_r && !(flow_eff == FLOW_SW && (rx_sh_r == xoff_r || rx_sh_r == xon_r))) begin
            rx_data_r  <= rx_sh_r;
            rx_valid_r <= 1'b1;
         end else if (acc && avs_req_i.read && avs_req_i.address == ADDR_RXDATA) begin
            rx_valid_r <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   a_dtr_under_hw: assert property (flow_eff == FLOW_HW |=> dtr_o) // R14
      else $error("DTR low under hardware flow control");
   a_rts_always_on: assert property (flow_eff == FLOW_HW && eff_cfg.rts_always [*2] |-> rts_o) // R12
      else $error("RTS dropped in always-on mode");
   a_rs485_no_flow: assert property (rs485_s [*2] |-> !rts_o && !dtr_o) // R6
      else $error("Handshake active on RS-485 variant");
   a_hold_no_start: assert property (tx_state_r == TX_HOLD && !go |=> tx_state_r != TX_SHIFT) // R10
      else $error("Character started without permission");
   a_abort_sticky: assert property (tx_abort |=> abort_err_r && tx_state_r == TX_IDLE && !hold_valid_r) // R5
      else $error("Abort not reported");
   a_xchar_distinct: assert property (xon_r != xoff_r) // R18
      else $error("XON equals XOFF");
   a_run_drop_cfg: assert property ($fell(run_r) |=> !run_valid_r && eff_cfg == stored_cfg_r) // R21
      else $error("Runtime settings survived stop");
   a_start_bit_low: assert property ($rose(tx_state_r == TX_SHIFT) |-> !txd_o) // R22
      else $error("Frame did not begin with start bit");
   a_idle_line_high: assert property (tx_state_r != TX_SHIFT |-> txd_o) // R22
      else $error("Line not idle between characters");
   a_wait_bound: assert property (tx_state_r == TX_HOLD && !go |-> ms_cnt_r <= eff_cfg.wait_ms) // R4
      else $error("Wait counter passed wait time");
   a_xoff_halts: assert property (flow_eff == FLOW_SW && xoff_held_r |-> !tx_take) // R16
      else $error("Sent while XOFF held");
   a_switched_rts: assert property (flow_eff == FLOW_HW && !eff_cfg.rts_always && tx_state_r == TX_SHIFT
                                    ##1 flow_eff == FLOW_HW |-> rts_o) // R9
      else $error("RTS low while sending in switched mode");

   c_abort_seen:  cover property (tx_abort);
   c_xoff_resume: cover property (xoff_held_r ##1 !xoff_held_r ##[1:100] tx_take);
   c_frame_done:  cover property (tx_state_r == TX_SHIFT ##1 tx_state_r == TX_IDLE);
   c_runtime_cfg: cover property ($rose(run_valid_r));

endmodule : spfc_top
`default_nettype wire

// ### dv/spfc_remote.sv
// Far-side modem model: answers RTS with CTS, drives DSR and rxd
`timescale 1ns/10ps
`default_nettype none
module spfc_remote
   import spfc_pkg::*;
(
   // Clock and bench controls
   input  wire logic clk_i,
   input  wire logic cts_req_i,
   input  wire logic dsr_req_i,
   // Serial pins
   input  wire logic rts_i,
   output var  logic rxd_o,
   output var  logic cts_o,
   output var  logic dsr_o
);
   initial rxd_o = 1'b1;
   // Clear to send only while asked and allowed
   assign cts_o = cts_req_i & rts_i;
   assign dsr_o = dsr_req_i;
   // Lone 8N1 ASCII characters, so the receiver is never overrun
   task automatic send_char(input logic [7:0] c);
      logic [9:0] f;
      f = {1'b1, c, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge clk_i) rxd_o <= f[i];
         repeat (int'(BIT_DIV[10]) - 1) @(posedge clk_i);
      end
   endtask : send_char
endmodule : spfc_remote
`default_nettype wire

// ### dv/tb_top.sv
// Self-checking bench for the serial port with flow control
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin errors++; \
   $display("[ERR] %s exp %h got %h", n, e, s); end end
module tb_top
   import spfc_pkg::*;
;
   localparam int MS  = 10;
   localparam int BIT = int'(BIT_DIV[10]);
   logic          clk_i, sys_rst_i, cts_req, dsr_req, rs485;
   spfc_avs_req_t req;
   logic [31:0]   rdata;
   logic [7:0]    ch;
   wire logic [31:0] rdat;
   wire logic     wrq, txd, rts, dtr, rxd, cts, dsr;
   int            errors, n_compared, cyc;
   spfc_top #(.MS_CYCLES(MS)) spfc_top_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .avs_req_i(req), .avs_readdata_o(rdat), .avs_waitrequest_o(wrq), .rxd_i(rxd),
      .cts_i(cts), .dsr_i(dsr), .rs485_variant_i(rs485), .txd_o(txd), .rts_o(rts), .dtr_o(dtr));
   spfc_remote spfc_remote_inst (.clk_i(clk_i), .cts_req_i(cts_req), .dsr_req_i(dsr_req),
      .rts_i(rts), .rxd_o(rxd), .cts_o(cts), .dsr_o(dsr));
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   task automatic test_done;
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : test_done
   // Hang guard well above the longest sequence
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 80000) begin
         errors++;
         test_done();
      end
   end
   task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d);
      @(posedge clk_i);
      req <= '{read: !w, write: w, address: a, writedata: d, byteenable: 4'hf};
      do @(posedge clk_i); while (wrq !== 1'b0);
      rdata = rdat;
      req <= '0;
   endtask : acc
   task automatic getch(output logic [7:0] c, input logic p);
      wait (txd === 1'b0);
      repeat (BIT / 2) @(posedge clk_i);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT) @(posedge clk_i);
         c[i] = txd;
      end
      repeat (BIT) @(posedge clk_i);
      `CHK("bit8", p, txd)
   endtask : getch
   initial begin
      sys_rst_i = 1'b1; req = '0; cts_req = 1'b0; dsr_req = 1'b1; rs485 = 1'b0;
      repeat (4) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      acc(0, ADDR_STORED, 0); `CHK("stored", 32'h03e8_0005, rdata)
      // Bad baud index and equal codes are refused
      acc(1, ADDR_STORED, 32'h0005_010b);
      acc(1, ADDR_XCHAR, 32'h0000_2222);
      acc(0, ADDR_STATUS, 0); `CHK("cfg_err", 1'b1, rdata[ST_CFGERR])
      acc(0, ADDR_XCHAR, 0); `CHK("xchar", {16'h0, XOFF_RST, XON_RST}, rdata)
      // Switched RTS with CTS withheld
      acc(1, ADDR_STORED, 32'h0005_010a);
      acc(1, ADDR_TXDATA, 32'h55);
      repeat (3) @(posedge clk_i);
      `CHK("rts", 1'b1, rts)
      `CHK("dtr", 1'b1, dtr)
      repeat (5 * MS - 15) @(posedge clk_i);
      `CHK("held", 1'b1, txd)
      acc(0, ADDR_STATUS, 0); `CHK("early", 1'b0, rdata[ST_ABORT])
      repeat (20) @(posedge clk_i);
      acc(0, ADDR_STATUS, 0); `CHK("abort", 1'b1, rdata[ST_ABORT])
      acc(1, ADDR_STATUS, 32'h0000_000c);
      cts_req <= 1'b1;
      acc(1, ADDR_TXDATA, 32'ha5);
      getch(ch, 1'b1); `CHK("tx", 8'ha5, ch)
      // Always-on RTS is up before any data is written; DSR gates the start of a send
      acc(1, ADDR_STORED, 32'h0005_050a);
      dsr_req <= 1'b0;
      repeat (BIT) @(posedge clk_i);
      `CHK("rts on", 1'b1, rts)
      acc(1, ADDR_TXDATA, 32'h33);
      repeat (20) @(posedge clk_i);
      `CHK("no dsr", 1'b1, txd)
      dsr_req <= 1'b1;
      getch(ch, 1'b1); `CHK("dsr tx", 8'h33, ch)
      // Software flow: XOFF halts, silence aborts, XON resumes
      acc(1, ADDR_STORED, 32'h0005_020a);
      spfc_remote_inst.send_char(XOFF_RST);
      repeat (20) @(posedge clk_i);
      acc(1, ADDR_TXDATA, 32'h80);
      acc(0, ADDR_STATUS, 0); `CHK("xoff", 2'h3, {rdata[ST_XOFF], rdata[ST_CFGERR]})
      acc(0, ADDR_RXDATA, 0); `CHK("rx flow", 1'b0, rdata[RX_VALID_BIT])
      acc(1, ADDR_TXDATA, 32'h41);
      repeat (6 * MS) @(posedge clk_i);
      acc(0, ADDR_STATUS, 0); `CHK("no xon", 1'b1, rdata[ST_ABORT])
      spfc_remote_inst.send_char(XON_RST);
      repeat (20) @(posedge clk_i);
      acc(1, ADDR_TXDATA, 32'h41);
      getch(ch, 1'b1); `CHK("resume", 8'h41, ch)
      spfc_remote_inst.send_char(8'h5a);
      acc(0, ADDR_RXDATA, 0); `CHK("rx", 9'h15a, rdata[8:0])
      // Even parity: two ones in 8'h41, so the parity bit is 0
      acc(1, ADDR_STORED, 32'h0005_001a);
      acc(1, ADDR_TXDATA, 32'h41);
      getch(ch, 1'b0); `CHK("parity", 8'h41, ch)
      // Runtime settings last only in run
      acc(1, ADDR_CTRL, 32'h1);
      acc(1, ADDR_RUNCFG, 32'h0005_0009);
      acc(0, ADDR_STATUS, 0); `CHK("run cfg", 1'b1, rdata[ST_RUNCFG])
      acc(1, ADDR_CTRL, 32'h0);
      acc(0, ADDR_STATUS, 0); `CHK("stop cfg", 1'b0, rdata[ST_RUNCFG])
      rs485 <= 1'b1;
      acc(1, ADDR_STORED, 32'h0005_010a);
      repeat (4) @(posedge clk_i);
      `CHK("485 dtr", 1'b0, dtr)
      test_done();
   end
endmodule : tb_top
`default_nettype wire
